/* File: rtl/lbc_defines.svh */
// Constants for the local bus cycle controller
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH
`define LBC_DW 64
`define LBC_AW 30
`define LBC_NBYTE 8
`define LBC_MAX_OUT 2'd3
`define LBC_LAST_OFS 3'd7
`define LBC_ZERO_OFS 3'd0
`define LBC_FIFO_DEPTH 16
`define LBC_ONE_BYTE 8'h01
`define LBC_TWO_BYTE 8'h03
`define LBC_FOUR_BYTE 8'h0f
`define LBC_ALL_BYTE 8'hff
`define LBC_RST_BIG 1'b0
`endif

/* File: rtl/lbc_pkg.sv */
// Types for the local bus cycle controller
`include "lbc_defines.svh"
package lbc_pkg;
	typedef enum logic [1:0] {LBC_SZ_BYTE, LBC_SZ_HALF, LBC_SZ_WORD,
		LBC_SZ_DBL} lbc_size_e;
	typedef enum {LBC_IDLE, LBC_START, LBC_DONE} lbc_state_e;
	typedef struct packed {
		logic [31:0] addr;
		lbc_size_e size;
		logic write;
		logic fetch;
		logic same_page;
		logic page_attr;
		logic [`LBC_DW-1:0] wdata;
	} lbc_req_s;
	typedef struct packed {
		logic fetch;
		logic [2:0] shift;
		lbc_size_e size;
	} lbc_tag_s;
	typedef struct packed {
		logic [`LBC_DW-1:0] rdata;
		logic write;
	} lbc_resp_s;
endpackage

/* File: rtl/lbc_fifo.sv */
// Request FIFO with valid and ready on both sides
`timescale 1ns/1ns
`include "lbc_defines.svh"
module lbc_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Sync reset
	input wire logic ce, // Clock enable
	input wire logic in_valid, // Write side valid
	output logic in_ready, // Not full
	input wire logic [W-1:0] in_data, // Write data
	output logic out_valid, // Not empty
	input wire logic out_ready, // Read side ready
	output logic [W-1:0] out_data // Head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;
	logic push;
	logic pop;
	assign in_ready = (wr_r - rd_r) != (AW+1)'(D);
	assign out_valid = wr_r != rd_r;
	assign out_data = mem[rd_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk_sys)
	begin
		if (ce && push)
			mem[wr_r[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else if (ce)
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
		end
	end
endmodule

/* File: rtl/lbc_bus_ctrl.sv */
// Nonpipelined local bus master with endian byte steering
//
// Contract
// - Reset to little endian; supervisor may switch endian mode any time.
// - Loads shift bus word right so item lsb lands in byte zero.
// - Stores shift data left onto lanes; enable only written lanes.
// - Shift and enables come from address bits 2:0, size, endian.
// - Little endian byte at offset zero: no shift, lowest lane only.
// - Big endian byte at offset zero: seven byte shift, top lane only.
// - Big endian maps byte offset to seven minus offset.
// - Instruction fetches always use little endian addressing.
// - All bus control inputs are sampled on the rising edge.
// - Cycle starts with strobe, ends when cycle-done sampled active.
// - New cycle no sooner than one clock after previous start.
// - At most three cycles outstanding; pipelining needs one or two.
// - Every cycle lasts at least start state plus one completion.
// - Idle without request; on request enter start, assert strobe.
// - Start always followed by completion; address, controls valid.
// - Data bus floated during read cycles.
// - Write data and lane enables valid by first completion end.
// - Repeat completion state, hold signals while cycle-done inactive.
// - On cycle-done go idle, or straight to start if requested.
// - Write after read delayed one clock; data driven from completion.
// - Next-address grant honoured only while strobe inactive; here the grant is synchronised but never used.
`timescale 1ns/1ns
`include "lbc_defines.svh"
module lbc_bus_ctrl
	import lbc_pkg::*;
(
	input wire logic clk_sys, // 100 MHz clock
	input wire logic rst, // Sync reset, active high
	input wire logic ce, // Clock enable, freezes state
	input wire logic supervisor, // Supervisor mode qualifier
	input wire logic endian_wr, // Pulse: write endian mode
	input wire logic endian_big, // New endian mode, 1 = big
	output logic endian_big_r, // Current data endian mode
	input wire logic req_valid, // Request valid
	output logic req_ready, // Request taken into FIFO
	input wire lbc_req_s req, // Request fields
	output logic resp_valid, // Pulse: cycle finished
	output lbc_resp_s resp, // Aligned load data
	output logic [`LBC_AW-1:0] addr_out, // Address lines 32:3
	output logic wr_not_rd, // Write not read
	output logic same_page_hint_n, // Same page hint
	output logic page_attr_bit, // Page attribute bit
	output logic address_strobe_n, // Address strobe
	output logic [`LBC_NBYTE-1:0] byte_lane_enable_n, // Lane enables
	output logic [`LBC_DW-1:0] data_out, // Data bus drive
	output logic data_oe_n, // Data drive enable, low drives
	input wire logic [`LBC_DW-1:0] data_in, // Data bus pins
	input wire logic ready_n, // Cycle done pin
	input wire logic next_addr_grant_n // Next-address grant pin
);
	// Offset of the last byte of an item within itself
	function automatic logic [2:0] size_last(input lbc_size_e sz);
		case (sz)
			LBC_SZ_BYTE: size_last = 3'd0;
			LBC_SZ_HALF: size_last = 3'd1;
			LBC_SZ_WORD: size_last = 3'd3;
			default: size_last = 3'd7;
		endcase
	endfunction

	// Byte offset after endian mapping, and lane mask
	function automatic logic [2:0] lane_ofs(input logic [2:0] a,
		input lbc_size_e sz, input logic big);
		if (big)
			lane_ofs = `LBC_LAST_OFS - a - size_last(sz);
		else
			lane_ofs = a;
	endfunction
	function automatic logic [7:0] lane_mask(input lbc_size_e sz);
		case (sz)
			LBC_SZ_BYTE: lane_mask = `LBC_ONE_BYTE;
			LBC_SZ_HALF: lane_mask = `LBC_TWO_BYTE;
			LBC_SZ_WORD: lane_mask = `LBC_FOUR_BYTE;
			default: lane_mask = `LBC_ALL_BYTE;
		endcase
	endfunction

	// Keeps only the bytes of the loaded item
	function automatic logic [`LBC_DW-1:0] item_mask(input lbc_size_e sz);
		logic [`LBC_NBYTE-1:0] ln;
		logic [`LBC_DW-1:0] m;
		ln = lane_mask(sz);
		m = '0;
		for (int i = 0; i < `LBC_NBYTE; i++)
			if (ln[i])
				m[8*i+:8] = 8'hff;
		item_mask = m;
	endfunction

	lbc_state_e state_r;
	logic ready_s1_r;
	logic ready_s2_r;
	logic na_s1_r;
	logic na_s2_r;
	logic [`LBC_DW-1:0] din_s1_r;
	logic [`LBC_DW-1:0] din_s2_r;
	logic last_read_r;
	logic fifo_valid;
	logic fifo_pop;
	lbc_req_s head;
	logic [2:0] head_ofs;
	logic head_big;
	lbc_tag_s tag_r;
	logic [`LBC_DW-1:0] rdata_nxt;
	logic cyc_end;
	logic wr_turn;
	logic [1:0] outst_r;
	logic [`LBC_NBYTE-1:0] head_lanes;
	logic [`LBC_DW-1:0] head_data;

	// Queue decouples the core from wait states on the bus
	lbc_fifo #(.W($bits(lbc_req_s)), .D(`LBC_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(req),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(head)
	);

	// Pins pass two flip-flops before use
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ready_s1_r <= 1'b1;
			ready_s2_r <= 1'b1;
		end
		else if (ce)
		begin
			ready_s1_r <= ready_n;
			ready_s2_r <= ready_s1_r;
		end
	end

	// Grant kept synchronised for a later pipelined version
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			na_s1_r <= 1'b1;
			na_s2_r <= 1'b1;
		end
		else if (ce)
		begin
			na_s1_r <= next_addr_grant_n;
			na_s2_r <= na_s1_r;
		end
	end

	// Read data travels with cycle-done so both line up
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			din_s1_r <= '0;
			din_s2_r <= '0;
		end
		else if (ce)
		begin
			din_s1_r <= data_in;
			din_s2_r <= din_s1_r;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			endian_big_r <= `LBC_RST_BIG;
		else if (ce && endian_wr && supervisor)
			endian_big_r <= endian_big;
	end

	// Fetches keep little endian whatever the data mode
	assign head_big = endian_big_r && !head.fetch;
	assign head_ofs = lane_ofs(head.addr[2:0], head.size, head_big);
	assign head_lanes = ~(lane_mask(head.size) << head_ofs);
	// Done as seen through the synchroniser closes the cycle
	assign cyc_end = state_r == LBC_DONE && !ready_s2_r;
	// A write right behind a read waits one clock in idle
	assign wr_turn = head.write && last_read_r &&
		state_r != LBC_IDLE;
	// Grant is not used: one cycle outstanding at most, the
	// limit of three is never approached
	assign fifo_pop = ce && fifo_valid && !wr_turn &&
		outst_r != `LBC_MAX_OUT &&
		(state_r == LBC_IDLE || cyc_end);

	// Cycles started and not yet ended
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			outst_r <= 2'd0;
		else if (ce)
		begin
			if (fifo_pop && !cyc_end)
				outst_r <= outst_r + 2'd1;
			else if (cyc_end && !fifo_pop)
				outst_r <= outst_r - 2'd1;
		end
	end

	// Cycle state sequence
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_r <= LBC_IDLE;
		else if (ce)
		begin
			case (state_r)
				LBC_IDLE:
					if (fifo_pop)
						state_r <= LBC_START;
				LBC_START:
					state_r <= LBC_DONE;
				LBC_DONE:
					if (!ready_s2_r)
						state_r <= fifo_pop ? LBC_START : LBC_IDLE;
					else
						state_r <= LBC_DONE;
				default:
					state_r <= LBC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			last_read_r <= 1'b0;
		else if (ce && fifo_pop)
			last_read_r <= !head.write;
	end

	// Strobe only in the start state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			address_strobe_n <= 1'b1;
		else if (ce)
			address_strobe_n <= !fifo_pop;
	end

	// Write data: each lane takes the item byte that lands on it
	for (genvar g = 0; g < `LBC_NBYTE; g++)
	begin : g_wlane
		logic [2:0] src;
		assign src = 3'(g) - head_ofs;
		assign head_data[8*g+:8] = (3'(g) < head_ofs) ? 8'h00 :
			head.wdata[8*src+:8];
	end

	// Address lines, held through all wait states
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			addr_out <= '0;
		else if (ce && fifo_pop)
			addr_out <= {1'b0, head.addr[31:3]};
	end

	// Direction of the cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			wr_not_rd <= 1'b0;
		else if (ce && fifo_pop)
			wr_not_rd <= head.write;
	end

	// Same page hint, active low on the pin
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			same_page_hint_n <= 1'b1;
		else if (ce && fifo_pop)
			same_page_hint_n <= !head.same_page;
	end

	// Page attribute bit
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			page_attr_bit <= 1'b0;
		else if (ce && fifo_pop)
			page_attr_bit <= head.page_attr;
	end

	// Lane enables, also shown on reads
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			byte_lane_enable_n <= '1;
		else if (ce && fifo_pop)
			byte_lane_enable_n <= head_lanes;
	end

	// Write data, steady until the cycle ends
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			data_out <= '0;
		else if (ce && fifo_pop)
			data_out <= head_data;
	end

	// What the load path needs when the data arrives
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			tag_r <= '0;
		else if (ce && fifo_pop)
			tag_r <= '{fetch: head.fetch, shift: head_ofs, size: head.size};
	end

	// Data drive: reads float, writes drive from start, or from
	// completion when a read came just before
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			data_oe_n <= 1'b1;
		else if (ce)
		begin
			if (fifo_pop)
				data_oe_n <= !(head.write && !last_read_r);
			else if (state_r == LBC_START && wr_not_rd)
				data_oe_n <= 1'b0;
			else if (state_r == LBC_DONE && !ready_s2_r)
				data_oe_n <= 1'b1;
		end
	end

	// Loads: result byte g takes lane g plus the shift
	for (genvar g = 0; g < `LBC_NBYTE; g++)
	begin : g_rlane
		logic [2:0] src;
		assign src = 3'(g) + tag_r.shift;
		assign rdata_nxt[8*g+:8] = (src < 3'(g)) ? 8'h00 :
			din_s2_r[8*src+:8];
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			resp_valid <= 1'b0;
		else if (ce)
			resp_valid <= cyc_end;
	end

	// Load data is right aligned and cut to the item size
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			resp <= '0;
		else if (ce && cyc_end)
		begin
			resp.rdata <= wr_not_rd ? '0 :
				rdata_nxt & item_mask(tag_r.size);
			resp.write <= wr_not_rd;
		end
	end
endmodule

/* File: bench/lbc_monitor.sv */
// Bus cycle checker bound to the controller
`timescale 1ns/1ns
`include "lbc_defines.svh"
module lbc_monitor (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic endian_big_r, // Mode
	input wire logic resp_valid, // End
	input wire logic wr_not_rd, // Dir
	input wire logic address_strobe_n, // Strobe
	input wire logic [`LBC_NBYTE-1:0] byte_lane_enable_n, // Lanes
	input wire logic [`LBC_AW-1:0] addr_out, // Addr
	input wire logic data_oe_n, // Drive
	input wire logic ready_n // Done
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic prev_rd;
	// Direction of the cycle before the one now starting
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			prev_rd <= 1'b0;
		else if (!address_strobe_n)
			prev_rd <= !wr_not_rd;
	end
	a_reset_idle: assert property ($fell(rst) |->
		address_strobe_n && data_oe_n && !endian_big_r) else $error("busy");
	a_strobe_gap: assert property (!address_strobe_n |=>
		address_strobe_n [*2]) else $error("strobe gap");
	a_read_float: assert property (!wr_not_rd |-> data_oe_n)
		else $error("read drives bus");
	a_wr_drive: assert property (wr_not_rd && !$past(address_strobe_n)
		|-> !data_oe_n) else $error("write data late");
	a_wr_turn: assert property (!address_strobe_n && wr_not_rd
		&& prev_rd |-> data_oe_n) else $error("turnaround");
	a_wr_early: assert property (!address_strobe_n && wr_not_rd
		&& !prev_rd |-> !data_oe_n) else $error("write not driven");
	a_sig_hold: assert property (address_strobe_n |->
		$stable(addr_out) && $stable(byte_lane_enable_n)) else $error("hold");
	a_done_bound: assert property (!ready_n |-> ##[1:6] resp_valid)
		else $error("no end");
	a_lane_size: assert property (!address_strobe_n && wr_not_rd |->
		$countones(~byte_lane_enable_n) inside {1, 2, 4, 8}) else $error("ln");
	c_turn: cover property (!address_strobe_n && wr_not_rd && !$past(wr_not_rd));
	c_read: cover property (resp_valid && !wr_not_rd);
	c_big: cover property (!address_strobe_n && endian_big_r);
endmodule
bind lbc_bus_ctrl lbc_monitor mon_u (.*);

/* File: bench/lbc_mem.sv */
// Memory side model answering bus cycles
`timescale 1ns/1ns
`include "lbc_defines.svh"
module lbc_mem (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic [3:0] waits, // Wait states
	input wire logic address_strobe_n, // Strobe
	input wire logic wr_not_rd, // Dir
	input wire logic [`LBC_AW-1:0] addr_out, // Addr
	input wire logic [`LBC_NBYTE-1:0] byte_lane_enable_n, // Lanes
	input wire logic [`LBC_DW-1:0] data_out, // Write data
	output logic ready_n, // Done
	output logic [`LBC_DW-1:0] data_in // Read data
);
	logic [`LBC_DW-1:0] mem [8] = '{default: '0};
	logic act = 1'b0;
	logic rd = 1'b0;
	logic [2:0] hold = 3'd0;
	logic [4:0] cnt = 5'd0;
	wire logic [`LBC_DW-1:0] word = mem[addr_out[2:0]];
	// Released bus keeps the word four more clocks, then shows the inverse
	assign data_in = (rd && (act || hold != 0)) ? word : ~word;
	assign ready_n = !(act && cnt == 0);
	always @(posedge clk_sys)
	begin
		hold <= (hold != 0) ? hold - 1 : hold;
		if (rst)
			act <= 1'b0;
		else if (!address_strobe_n)
		begin
			act <= 1'b1;
			rd <= !wr_not_rd;
			cnt <= 5'(waits) + 5'(wr_not_rd && rd);
		end
		else if (act && cnt != 0)
			cnt <= cnt - 1;
		else if (act)
		begin
			act <= 1'b0;
			hold <= 3'd4;
			for (int j = 0; j < 8; j++)
				if (!byte_lane_enable_n[j] && !rd)
					mem[addr_out[2:0]][8*j+:8] <= data_out[8*j+:8];
		end
	end
endmodule

/* File: bench/local_bus_cycle_and_endian_steering_tb.sv */
// Random bus traffic against a byte model of memory
`timescale 1ns/1ns
`include "lbc_defines.svh"
module local_bus_cycle_and_endian_steering_tb
	import lbc_pkg::*;
;
	typedef struct {logic [63:0] a, d, m; logic [7:0] ln; logic w;} lbc_exp_s;
	lbc_exp_s sq[$], rq[$], cur, r;
	logic [7:0] bm [64] = '{default: '0};
	logic clk_sys = 0, rst = 1, ce = 1, supervisor = 0, endian_wr = 0;
	logic endian_big = 0, req_valid = 0, next_addr_grant_n = 1;
	logic endian_big_r, req_ready, resp_valid, wr_not_rd, data_oe_n, ready_n;
	logic same_page_hint_n, page_attr_bit, address_strobe_n, mode = 0;
	logic dchk = 0, w, f;
	lbc_size_e sz;
	lbc_req_s req = '0;
	lbc_resp_s resp;
	logic [`LBC_AW-1:0] addr_out;
	logic [`LBC_NBYTE-1:0] byte_lane_enable_n;
	logic [`LBC_DW-1:0] data_out, data_in;
	logic [3:0] waits = 0;
	int errors = 0, cmp_count = 0, refused = 0, wmax = 3;
	lbc_bus_ctrl dut_u (.*);
	lbc_mem mem_u (.*);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		next_addr_grant_n <= 1'($urandom);
	task close_out();
		$display("%0d mismatches, %0d compares", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [63:0] g, e);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task push(input lbc_size_e s, input logic wr, fe);
		lbc_exp_s e;
		int n, o, k;
		logic [31:0] a;
		logic [63:0] d;
		n = 1 << s;
		a = $urandom & ~(n - 1);
		d = {$urandom, $urandom};
		k = $urandom;
		o = (mode && !fe) ? 8 - n - a[2:0] : a[2:0];
		e.m = ((64'h1 << 8 * n) - 1) << 8 * o;
		e.ln = ~8'(((16'h1 << n) - 1) << o);
		e.w = wr;
		e.a = {k[1], !k[0], 1'b0, a[31:3]};
		e.d = (d << 8 * o) & e.m;
		for (int j = 0; j < 8; j++)
			if (!wr)
				e.d[8*j+:8] = bm[8*a[5:3]+j];
			else if (e.m[8*j])
				bm[8*a[5:3]+j] = e.d[8*j+:8];
		if (!wr)
		begin
			e.d = (e.d & e.m) >> 8 * o;
			e.m = e.m >> 8 * o;
		end
		sq.push_back(e);
		@(posedge clk_sys);
		waits <= 4'($urandom % wmax);
		req_valid <= 1'b1;
		req <= '{a, s, wr, fe, k[0], k[1], d};
		@(negedge clk_sys);
		while (req_ready !== 1'b1)
		begin
			refused++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		req_valid <= 1'b0;
	endtask
	task set_mode(input logic s, b);
		@(posedge clk_sys);
		supervisor <= s;
		endian_big <= b;
		endian_wr <= 1'b1;
		@(posedge clk_sys);
		endian_wr <= 1'b0;
		mode = s ? b : mode;
		@(negedge clk_sys);
		chk(endian_big_r, mode);
	endtask
	task drain();
		while (sq.size() != 0 || rq.size() != 0)
			@(negedge clk_sys);
	endtask
	always @(negedge clk_sys)
	begin
		if (dchk && cur.w)
			chk(data_out & cur.m, cur.d);
		dchk = 0;
		if (address_strobe_n === 1'b0)
		begin
			cur = sq.pop_front();
			dchk = 1;
			rq.push_back(cur);
			chk({page_attr_bit, same_page_hint_n, addr_out}, cur.a);
			chk(byte_lane_enable_n, cur.ln);
		end
		if (resp_valid === 1'b1)
		begin
			r = rq.pop_front();
			chk(resp.write, r.w);
			if (!r.w)
				chk(resp.rdata, r.d);
		end
	end
	initial
	begin
		#400000;
		errors++;
		close_out();
	end
	initial
	begin
		void'($urandom(32'he667));
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk(endian_big_r, 0);
		push(LBC_SZ_DBL, 0, 0);
		set_mode(0, 1);
		set_mode(1, 1);
		$display("test endian done");
		for (int i = 0; i < 60; i++)
		begin
			sz = lbc_size_e'($urandom % 4);
			w = 1'($urandom);
			f = !w && $urandom % 4 == 0;
			push(f ? LBC_SZ_WORD : sz, w, f);
			if (i % 15 == 14)
			begin
				drain();
				set_mode(1, 1'($urandom));
			end
		end
		drain();
		$display("test random done");
		refused = 0;
		wmax = 16;
		repeat (24) push(LBC_SZ_DBL, 1, 0);
		chk(refused != 0, 1);
		drain();
		$display("test fill done");
		close_out();
	end
endmodule
